// *** dv/srw_cpu_model.sv ***
`timescale 1ns/1ns
module srw_cpu_model
#(
	parameter int KICK_PER = 900 // Clocks between kick toggles
)
(
	input  wire logic core_clk, // System clock
	input  wire logic resetAct, // Reset asserted
	input  wire logic kickOn,   // Software alive
	input  wire logic floatOn,  // Kick pin released
	output logic      kick,     // Kick pin
	output logic      floatInd  // Kick pin floating
);
	logic drv = 1'b0;
	int   cnt = 0;

	// Released pin shows inverse, not a held copy
	assign kick     = floatOn ? ~drv : drv;
	assign floatInd = floatOn;

	always @(negedge core_clk)
	begin
		if (resetAct || !kickOn)
			cnt <= 0;
		else
			cnt <= (cnt >= KICK_PER - 1) ? 0 : cnt + 1;
		if (resetAct)
			drv <= 1'b0;
		else if (kickOn && !floatOn && cnt >= KICK_PER - 1)
			drv <= ~drv;
	end
endmodule

// *** dv/test_supervisor_reset_watchdog.sv ***
`timescale 1ns/1ns
module test_supervisor_reset_watchdog;
	localparam int HC = 4 * 125;
	localparam int WC = 10 * 125;
	// One tick of jitter plus sync delay
	localparam int M  = 135;
	logic core_clk  = 1'b0;
	logic rst       = 1'b1;
	logic supplyLow = 1'b0;
	logic manRstN   = 1'b1;
	logic kickOn    = 1'b1;
	logic floatOn   = 1'b0;
	logic kick;
	logic floatInd;
	logic rOut;
	logic rOutH;
	int   bad_count = 0;
	int   cmp_count = 0;

	always #4 core_clk = ~core_clk;

	srw_supervisor #(.HOLD_CYC(4), .WDOG_CYC(10)) DUT (.core_clk(core_clk), .rst(rst),
		.supplyLow(supplyLow), .manual_reset_in_low_active(manRstN), .watchdog_kick_in(kick),
		.watchdogOff(floatInd), .resetOut(rOut));
	srw_supervisor #(.ACTIVE_HIGH(1'b1), .HOLD_CYC(4), .WDOG_CYC(10)) dutHigh (.core_clk(core_clk), .rst(rst),
		.supplyLow(supplyLow), .manual_reset_in_low_active(manRstN), .watchdog_kick_in(kick),
		.watchdogOff(floatInd), .resetOut(rOutH));
	srw_cpu_model cpu (.core_clk(core_clk), .resetAct(rOut === 1'b0), .kickOn(kickOn),
		.floatOn(floatOn), .kick(kick), .floatInd(floatInd));

	task give_verdict;
		$display("Compares %0d, errors %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
			bad_count++;
		end
	endtask

	task stay(input logic exp, input int n);
		for (int i = 0; i < n && rOut === exp; i++)
			@(negedge core_clk);
		chk(rOut, exp);
	endtask

	task reach(input logic exp, input int n);
		for (int i = 0; i < n && rOut !== exp; i++)
			@(negedge core_clk);
		chk(rOut, exp);
		if (rOut !== exp)
			give_verdict();
	endtask

	task src(input bit supply);
		if (supply)
			supplyLow = 1'b1;
		else
			manRstN = 1'b0;
		reach(1'b0, 8);
		stay(1'b0, 300);
		supplyLow = 1'b0;
		manRstN = 1'b1;
		stay(1'b0, HC - M);
		reach(1'b1, 2 * M);
	endtask

	// Timer starts at hold release, kicks stopped there
	task wdog_run;
		kickOn = 1'b0;
		stay(1'b1, WC - M);
		reach(1'b0, 2 * M);
		stay(1'b0, HC - M);
		reach(1'b1, 2 * M);
		stay(1'b1, WC - M);
		reach(1'b0, 2 * M);
		kickOn = 1'b1;
		reach(1'b1, HC + 2 * M);
	endtask

	// Mid-run reset acts as a source: one hold time after release
	task rst_run;
		rst = 1'b1;
		reach(1'b0, 3);
		rst = 1'b0;
		stay(1'b0, HC - M);
		reach(1'b1, 2 * M);
	endtask

	always @(negedge core_clk)
		chk(rOutH, ~rOut);

	initial
	begin
		repeat (3) @(negedge core_clk);
		rst = 1'b0;
		reach(1'b1, HC + 2 * M);
		src(1'b0);
		src(1'b1);
		wdog_run();
		stay(1'b1, 3 * WC);
		floatOn = 1'b1;
		kickOn = 1'b0;
		stay(1'b1, 2 * WC);
		rst_run();
		give_verdict();
	end
endmodule

// *** src/srw_pkg.sv ***
package srw_pkg;
	// Internal time base
	localparam int  CLK_MHZ         = 125;
	localparam int  TICK_DIV        = 125;
	localparam int  TICK_PER_MS     = 1000;
	localparam int  HOLD_TIME_MS    = 215;
	localparam int  WDOG_TIME_MS    = 1500;
	localparam int  HOLD_TICKS      = HOLD_TIME_MS * TICK_PER_MS;
	localparam int  WDOG_TICKS      = WDOG_TIME_MS * TICK_PER_MS;
	localparam int  CNT_W           = 21;
	localparam int  DIV_W           = 7;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

	typedef enum logic [1:0]
	{
		SRW_IDLE = 2'b01,
		SRW_HOLD = 2'b10
	} srw_state_e;

	typedef struct packed
	{
		logic undervolt;
		logic manualLow;
		logic kick;
		logic wdogOff;
	} srw_in_s;
endpackage

// *** src/srw_supervisor.sv ***
`timescale 1ns/1ns
module srw_supervisor
	import srw_pkg::*;
#(
	parameter bit          ACTIVE_HIGH = 1'b0,       // Output polarity build option
	parameter int unsigned HOLD_CYC    = HOLD_TICKS, // Hold time in ticks
	parameter int unsigned WDOG_CYC    = WDOG_TICKS  // Watchdog timeout in ticks
)
(
	input  wire logic core_clk,                   // 125 MHz clock
	input  wire logic rst,                        // Sync reset, high
	input  wire logic supplyLow,                  // Comparator: supply below threshold
	input  wire logic manual_reset_in_low_active, // Manual reset, low active
	input  wire logic watchdog_kick_in,           // Watchdog kick
	input  wire logic watchdogOff,                // Kick pin floating
	output logic      resetOut                    // Reset output, build polarity
);
	typedef struct packed
	{
		srw_state_e       state;
		logic [DIV_W-1:0] div;
		logic             tick;
		logic [CNT_W-1:0] holdCnt;
		logic [CNT_W-1:0] wdogCnt;
		logic             kickPrev;
		logic             active;
		logic             outPin;
	} srw_sv_s;

	srw_sv_s st_r;
	srw_sv_s st_nxt;
	srw_in_s pins;
	srw_in_s rawPins;
	logic    srcOn;
	logic    kickEdge;

	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);
	localparam logic [CNT_W-1:0] WDOG_LAST = CNT_W'(WDOG_CYC - 1);

	assign rawPins = '{undervolt: supplyLow, manualLow: manual_reset_in_low_active,
		kick: watchdog_kick_in, wdogOff: watchdogOff};
	srw_sync u_sync
	(
		.core_clk (core_clk),
		.rst      (rst),
		.pinIn    (rawPins),
		.pinSync  (pins)
	);

	// Prev flop resets to the idle pin level, so no false edge
	// Edge on either level
	assign kickEdge = pins.kick ^ st_r.kickPrev;
	assign srcOn = pins.undervolt | ~pins.manualLow;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.kickPrev = pins.kick;
		// Divider restarts on rst, so hold length repeats
		// Tick divider
		st_nxt.tick = (st_r.div == DIV_LAST);
		st_nxt.div = st_nxt.tick ? '0 : st_r.div + 1'b1;
		case (st_r.state)
			SRW_IDLE:
			begin
				st_nxt.holdCnt = '0;
				if (srcOn)
				begin
					st_nxt.state = SRW_HOLD;
					st_nxt.active = 1'b1;
					st_nxt.wdogCnt = '0;
				end
				else if (pins.wdogOff || kickEdge)
				begin
					st_nxt.wdogCnt = '0;
				end
				else if (st_r.tick)
				begin
					if (st_r.wdogCnt == WDOG_LAST)
					begin
						st_nxt.state = SRW_HOLD;
						st_nxt.active = 1'b1;
						st_nxt.wdogCnt = '0;
					end
					else
					begin
						st_nxt.wdogCnt = st_r.wdogCnt + 1'b1;
					end
				end
			end
			SRW_HOLD:
			begin
				st_nxt.wdogCnt = '0;
				// Divider free-runs: hold after a source may run up to one tick short
				// Restart hold while a source stays
				if (srcOn)
				begin
					st_nxt.holdCnt = '0;
				end
				else if (st_r.tick)
				begin
					if (st_r.holdCnt == HOLD_LAST)
					begin
						st_nxt.state = SRW_IDLE;
						st_nxt.active = 1'b0;
						st_nxt.holdCnt = '0;
					end
					else
					begin
						st_nxt.holdCnt = st_r.holdCnt + 1'b1;
					end
				end
			end
			default:
			begin
				st_nxt.state = SRW_HOLD;
				st_nxt.active = 1'b1;
			end
		endcase
		st_nxt.outPin = st_nxt.active ^ ~ACTIVE_HIGH;
	end

	// Reset counts as a reset source so the processor is held
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st_r <= '{state: SRW_HOLD, div: '0, tick: 1'b0, holdCnt: '0, wdogCnt: '0,
				kickPrev: 1'b0, active: 1'b1, outPin: ACTIVE_HIGH};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign resetOut = st_r.outPin;

	// Polarity consistency
	output_pol_a: assert property (@(posedge core_clk) disable iff (rst)
		resetOut == (st_r.active ^ ~ACTIVE_HIGH))
		else $error("reset output polarity wrong");
	active_high_a: assert property (@(posedge core_clk) disable iff (rst)
		ACTIVE_HIGH -> (resetOut == (st_r.state == SRW_HOLD)))
		else $error("active-high output mismatch");
	undervolt_a: assert property (@(posedge core_clk) disable iff (rst)
		pins.undervolt |=> st_r.active)
		else $error("undervolt did not assert reset");
	manual_a: assert property (@(posedge core_clk) disable iff (rst)
		!pins.manualLow |=> st_r.active)
		else $error("manual reset did not assert reset");
	hold_src_a: assert property (@(posedge core_clk) disable iff (rst)
		srcOn |=> st_r.holdCnt == '0)
		else $error("hold count not restarted by source");
	hold_len_a: assert property (@(posedge core_clk) disable iff (rst)
		$fell(st_r.active) |-> $past(st_r.holdCnt) == HOLD_LAST && $past(st_r.tick))
		else $error("reset released early");
	wdog_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		st_r.active |=> st_r.wdogCnt == '0)
		else $error("watchdog not cleared in reset");
	kick_edge_a: assert property (@(posedge core_clk) disable iff (rst)
		kickEdge |=> st_r.wdogCnt == '0)
		else $error("kick edge did not clear watchdog");
	wdog_off_a: assert property (@(posedge core_clk) disable iff (rst)
		pins.wdogOff |=> st_r.wdogCnt == '0)
		else $error("disabled watchdog counted");
	expiry_a: assert property (@(posedge core_clk) disable iff (rst)
		(st_r.state == SRW_IDLE && st_r.tick && st_r.wdogCnt == WDOG_LAST && !kickEdge && !pins.wdogOff)
		|=> st_r.active)
		else $error("watchdog expiry missed");
	tick_a: assert property (@(posedge core_clk) disable iff (rst)
		st_r.tick |=> !st_r.tick)
		else $error("tick wider than one cycle");
	// A one-cycle source pulse may end on a tick, which counts legally
	exp_once_a: assert property (@(posedge core_clk) disable iff (rst)
		$rose(st_r.active) && !srcOn && !st_r.tick |=> st_r.holdCnt == '0)
		else $error("expiry hold not from zero");

	// Counters never pass their last value
	wdog_bound_a: assert property (@(posedge core_clk) disable iff (rst)
		st_r.wdogCnt <= WDOG_LAST)
		else $error("watchdog count beyond timeout");
	hold_bound_a: assert property (@(posedge core_clk) disable iff (rst)
		st_r.holdCnt <= HOLD_LAST)
		else $error("hold count beyond hold time");
	state_code_a: assert property (@(posedge core_clk) disable iff (rst)
		$onehot(st_r.state))
		else $error("state code not one-hot");
	release_src_a: assert property (@(posedge core_clk) disable iff (rst)
		$fell(st_r.active) |-> !$past(srcOn))
		else $error("reset released while a source was active");

	// Main scenarios
	cov_manual: cover property (@(posedge core_clk) disable iff (rst) $fell(pins.manualLow));
	cov_uv: cover property (@(posedge core_clk) disable iff (rst) $rose(pins.undervolt));
	cov_release: cover property (@(posedge core_clk) disable iff (rst) $fell(st_r.active));
	cov_expiry: cover property (@(posedge core_clk) disable iff (rst)
		$rose(st_r.active) && !srcOn);
	cov_kick: cover property (@(posedge core_clk) disable iff (rst)
		kickEdge && st_r.state == SRW_IDLE);
endmodule

// *** src/srw_sync.sv ***
`timescale 1ns/1ns
module srw_sync
	import srw_pkg::*;
(
	input  wire logic    core_clk, // System clock
	input  wire logic    rst,      // Sync reset
	input  wire srw_in_s pinIn,    // Raw pins
	output srw_in_s      pinSync   // Synchronised pins
);
	typedef struct packed
	{
		srw_in_s s1;
		srw_in_s s2;
	} srw_sync_s;

	srw_sync_s st_r;
	srw_sync_s st_nxt;

	// Inactive levels at reset, except wdogOff, which resets to 1 (watchdog off)
	localparam srw_in_s IDLE_PINS = '{undervolt: 1'b0, manualLow: 1'b1, kick: 1'b0, wdogOff: 1'b1};

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = pinIn;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st_r <= '{s1: IDLE_PINS, s2: IDLE_PINS};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign pinSync = st_r.s2;
endmodule
